// ===== hdl/sfpg_pkg.sv
/*
 Package of the serial flash protect gate: protect codes, secured-region layout,
 command classes and timing figures.
 Assumes a 40 MHz system clock that samples the serial pins.
*/
package sfpg_pkg;

	localparam int ADDR_W           = 24;
	localparam int BLOCK_LSB        = 16;
	localparam int BLOCK_MSB        = 20;
	localparam int NUM_BLOCKS       = 32;
	localparam int OTP_BITS         = 4096;
	localparam int OTP_ADDR_W       = 9;
	localparam logic [8:0] OTP_ESN_LAST  = 9'h00F;
	localparam logic [8:0] OTP_LAST      = 9'h1FF;
	localparam int SECREG_FACTORY_BIT  = 0;
	localparam int SECREG_CUSTOMER_BIT = 1;
	localparam logic [1:0] SECREG_RESET  = 2'h0;
	localparam logic [3:0] PROTECT_RESET = 4'h0;
	localparam int CLK_PERIOD_PS    = 25000;
	localparam int OP_TIME_NS       = 1000;
	localparam int OP_CYCLES        = (OP_TIME_NS * 1000) / CLK_PERIOD_PS;

	typedef enum logic [3:0] {
		SFPG_CLS_NONE  = 4'h0,
		SFPG_CLS_READ  = 4'h1,
		SFPG_CLS_WRITE_ENABLE_CMD  = 4'h2,
		SFPG_CLS_WRITE_DISABLE_CMD  = 4'h3,
		SFPG_CLS_WRITE_STATUS_CMD  = 4'h4,
		SFPG_CLS_PROG  = 4'h5,
		SFPG_CLS_ERASE = 4'h6,
		SFPG_CLS_DPD   = 4'h7,
		SFPG_CLS_RDP   = 4'h8,
		SFPG_CLS_ENTER_SECURED_REGION_CMD  = 4'h9,
		SFPG_CLS_EXIT_SECURED_REGION_CMD  = 4'hA,
		SFPG_CLS_WRSEC = 4'hB,
		SFPG_CLS_RST   = 4'hC,
		SFPG_CLS_OTHER = 4'hD,
		SFPG_CLS_BAD   = 4'hF
	} sfpg_cls_t;

	typedef struct packed {
		sfpg_cls_t         cls;
		logic [ADDR_W-1:0] addr;
		logic [3:0]        new_protect;
		logic              new_sec_lock;
		logic              chip_erase;
	} sfpg_cmd_t;

	typedef struct packed {
		logic exec;
		logic rejected;
		logic protect_hit;
		logic otp_target;
	} sfpg_verdict_t;

endpackage

// ===== hdl/sfpg_gate.sv
/*
 Protect gate of a serial flash: samples the chip-select and serial clock pins,
 counts framing bits, and judges each decoded command against write enable, block
 protection, secured-region locks, busy and power-down state.
 Assumes an outside decoder supplies the command class on cmd_valid before
 chip-select rises, and that the array datapath acts on verdict_ff.exec.
*/
`timescale 1ns/1ps

module sfpg_gate
	import sfpg_pkg::*;
#(
	parameter int  OP_CNT          = OP_CYCLES,
	parameter logic FACTORY_LOCKED = 1'b0
)(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            cs_n_pin,
	input  wire logic            sclk_pin,
	input  wire logic            wp_n_pin,
	input  wire logic            quad_mode,
	input  wire logic            cmd_valid,
	input  wire sfpg_cmd_t       cmd,
	output logic                 active_ff,
	output logic                 so_oe_n_ff,
	output logic                 sample_ff,
	output logic                 shift_ff,
	output logic                 busy_ff,
	output logic                 write_enable_latch_ff,
	output logic                 secured_mode_ff,
	output logic                 deep_power_down_ff,
	output logic [3:0]           protect_code_ff,
	output logic                 status_write_protect_ff,
	output logic [1:0]           security_reg_ff,
	output sfpg_verdict_t        verdict_ff
);

	if (OP_CNT < 1 || OP_CNT > 32'h0000_FFFF)
	begin
		$error("OP_CNT must lie between 1 and 65535, the busy counter is sixteen bits");
	end

	function automatic logic [NUM_BLOCKS-1:0] protect_map(input logic [3:0] code);
		logic [NUM_BLOCKS-1:0] m;
		m = '0;
		unique case (code)
			4'h0: m = 32'h0000_0000;
			4'h1: m = 32'h8000_0000;
			4'h2: m = 32'hC000_0000;
			4'h3: m = 32'hF000_0000;
			4'h4: m = 32'hFF00_0000;
			4'h5: m = 32'hFFFF_0000;
			4'hA: m = 32'h0000_FFFF;
			4'hB: m = 32'h00FF_FFFF;
			4'hC: m = 32'h0FFF_FFFF;
			4'hD: m = 32'h3FFF_FFFF;
			4'hE: m = 32'h7FFF_FFFF;
			default: m = 32'hFFFF_FFFF;
		endcase
		return m;
	endfunction

	// Pins come from the host's domain; two flops before anything reads them.
	logic [1:0] cs_sync_ff, sclk_sync_ff, wp_sync_ff;
	logic       cs_q_ff, sclk_q_ff;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_sync_ff   <= 2'h3;
			sclk_sync_ff <= 2'h0;
			wp_sync_ff   <= 2'h3;
			cs_q_ff      <= 1'b1;
			sclk_q_ff    <= 1'b0;
		end
		else
		begin
			cs_sync_ff   <= {cs_sync_ff[0], cs_n_pin};
			sclk_sync_ff <= {sclk_sync_ff[0], sclk_pin};
			wp_sync_ff   <= {wp_sync_ff[0], wp_n_pin};
			cs_q_ff      <= cs_sync_ff[1];
			sclk_q_ff    <= sclk_sync_ff[1];
		end
	end

	logic cs_fall, cs_rise, sclk_rise, sclk_fall, selected;
	assign selected  = !cs_sync_ff[1];
	assign cs_fall   = cs_q_ff && !cs_sync_ff[1];
	assign cs_rise   = !cs_q_ff && cs_sync_ff[1];
	// Edges only count inside a frame, so the mode 0 or mode 3 idle level is harmless.
	assign sclk_rise = selected && !sclk_q_ff && sclk_sync_ff[1];
	assign sclk_fall = selected && sclk_q_ff && !sclk_sync_ff[1];

	logic [2:0]      bit_cnt_ff, nxt_bit_cnt;
	logic            ignore_ff, nxt_ignore;
	logic            nxt_active, nxt_so_oe_n;
	logic [15:0]     op_cnt_ff, nxt_op_cnt;
	logic            nxt_busy, nxt_wel, nxt_secured, nxt_dpd, nxt_swp;
	logic [3:0]      nxt_protect;
	logic [1:0]      nxt_secreg;
	sfpg_verdict_t   nxt_verdict;
	logic            byte_ok, hw_locked, hit, otp_locked, allowed, array_cmd, writer;
	logic [NUM_BLOCKS-1:0] pmap;
	logic [4:0]      blk;

	always_comb
	begin
		nxt_bit_cnt = bit_cnt_ff;
		nxt_ignore  = ignore_ff;
		nxt_active  = active_ff;
		nxt_so_oe_n = so_oe_n_ff;
		nxt_op_cnt  = op_cnt_ff;
		nxt_busy    = busy_ff;
		nxt_wel     = write_enable_latch_ff;
		nxt_secured = secured_mode_ff;
		nxt_dpd     = deep_power_down_ff;
		nxt_protect = protect_code_ff;
		nxt_swp     = status_write_protect_ff;
		nxt_secreg  = security_reg_ff;
		nxt_verdict = '0;
		byte_ok     = (bit_cnt_ff == 3'h0);
		hw_locked   = !wp_sync_ff[1] && status_write_protect_ff && !quad_mode;
		pmap        = protect_map(protect_code_ff);
		blk         = cmd.addr[BLOCK_MSB:BLOCK_LSB];
		hit         = cmd.chip_erase ? (|pmap) : pmap[blk];
		otp_locked  = security_reg_ff[SECREG_FACTORY_BIT] ||
		              security_reg_ff[SECREG_CUSTOMER_BIT];
		array_cmd   = (cmd.cls == SFPG_CLS_PROG) || (cmd.cls == SFPG_CLS_ERASE);
		writer      = array_cmd || (cmd.cls == SFPG_CLS_WRITE_STATUS_CMD) || (cmd.cls == SFPG_CLS_WRSEC);
		allowed     = 1'b0;

		if (busy_ff)
		begin
			// Nothing reaches the running operation; it just counts out.
			if (op_cnt_ff == 16'h0001)
				nxt_busy = 1'b0;
			nxt_op_cnt = op_cnt_ff - 16'h0001;
		end

		if (cs_fall)
		begin
			nxt_bit_cnt = 3'h0;
			nxt_ignore  = 1'b0;
			nxt_active  = 1'b1;
		end
		else if (selected && sclk_rise && !ignore_ff)
			nxt_bit_cnt = bit_cnt_ff + 3'h1;

		if (!selected || ignore_ff)
			nxt_so_oe_n = 1'b1;
		else if (sclk_fall && cmd_valid && cmd.cls == SFPG_CLS_READ && !deep_power_down_ff)
			nxt_so_oe_n = 1'b0;

		if (selected && cmd_valid && cmd.cls == SFPG_CLS_BAD && !ignore_ff)
		begin
			nxt_ignore  = 1'b1;
			nxt_active  = 1'b0;
		end

		if (cs_rise)
		begin
			nxt_active = 1'b0;
			if (cmd_valid && !ignore_ff && cmd.cls != SFPG_CLS_READ)
			begin
				if (!byte_ok)
					nxt_verdict.rejected = 1'b1;
				else if (deep_power_down_ff)
				begin
					if (cmd.cls == SFPG_CLS_RDP || cmd.cls == SFPG_CLS_RST)
					begin
						nxt_dpd = 1'b0;
						nxt_verdict.exec = 1'b1;
					end
					else
						nxt_verdict.rejected = 1'b1;
				end
				else if (busy_ff && writer)
					nxt_verdict.rejected = 1'b1;
				else
				begin
					unique case (cmd.cls)
						SFPG_CLS_WRITE_ENABLE_CMD:  begin nxt_wel = 1'b1; allowed = 1'b1; end
						SFPG_CLS_WRITE_DISABLE_CMD:  begin nxt_wel = 1'b0; allowed = 1'b1; end
						SFPG_CLS_DPD:   begin nxt_dpd = 1'b1; allowed = 1'b1; end
						SFPG_CLS_ENTER_SECURED_REGION_CMD:  begin nxt_secured = 1'b1; allowed = 1'b1; end
						SFPG_CLS_EXIT_SECURED_REGION_CMD:  begin nxt_secured = 1'b0; allowed = 1'b1; end
						SFPG_CLS_WRITE_STATUS_CMD:
						begin
							if (write_enable_latch_ff && !hw_locked)
							begin
								nxt_protect = cmd.new_protect;
								nxt_swp     = cmd.new_sec_lock;
								allowed     = 1'b1;
							end
						end
						SFPG_CLS_WRSEC:
						begin
							if (write_enable_latch_ff && !otp_locked)
							begin
								nxt_secreg[SECREG_CUSTOMER_BIT] = 1'b1;
								allowed = 1'b1;
							end
						end
						SFPG_CLS_PROG, SFPG_CLS_ERASE:
						begin
							nxt_verdict.otp_target = secured_mode_ff;
							nxt_verdict.protect_hit = hit && !secured_mode_ff;
							if (write_enable_latch_ff)
							begin
								if (secured_mode_ff)
									allowed = !otp_locked &&
									          cmd.addr[OTP_ADDR_W-1:0] <= OTP_LAST;
								else
									allowed = !hit;
							end
						end
						default: allowed = 1'b1;
					endcase
					if (writer)
						nxt_wel = 1'b0;
					if (allowed && writer)
					begin
						nxt_busy   = 1'b1;
						nxt_op_cnt = OP_CNT[15:0];
					end
					nxt_verdict.exec     = allowed;
					nxt_verdict.rejected = !allowed;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_ff              <= 3'h0;
			ignore_ff               <= 1'b0;
			active_ff               <= 1'b0;
			so_oe_n_ff              <= 1'b1;
			sample_ff               <= 1'b0;
			shift_ff                <= 1'b0;
			op_cnt_ff               <= 16'h0000;
			busy_ff                 <= 1'b0;
			write_enable_latch_ff   <= 1'b0;
			secured_mode_ff         <= 1'b0;
			deep_power_down_ff      <= 1'b0;
			protect_code_ff         <= PROTECT_RESET;
			status_write_protect_ff <= 1'b0;
			security_reg_ff         <= SECREG_RESET;
			verdict_ff              <= '0;
		end
		else
		begin
			bit_cnt_ff              <= nxt_bit_cnt;
			ignore_ff               <= nxt_ignore;
			active_ff               <= nxt_active;
			so_oe_n_ff              <= nxt_so_oe_n;
			sample_ff               <= sclk_rise && !ignore_ff;
			shift_ff                <= sclk_fall && !ignore_ff;
			op_cnt_ff               <= nxt_op_cnt;
			busy_ff                 <= nxt_busy;
			write_enable_latch_ff   <= nxt_wel;
			secured_mode_ff         <= nxt_secured;
			deep_power_down_ff      <= nxt_dpd;
			protect_code_ff         <= nxt_protect;
			status_write_protect_ff <= nxt_swp;
			// The factory bit is a strap caught after release and sticks once set.
			security_reg_ff         <= {nxt_secreg[1], nxt_secreg[0] | FACTORY_LOCKED};
			verdict_ff              <= nxt_verdict;
		end
	end

endmodule

// ===== verification/sfpg_ref.svh
/*
 Reference decode of the block protect codes.
 Assumes inclusion inside a module scope.
*/
`ifndef SFPG_REF_SVH
`define SFPG_REF_SVH
function automatic logic sfpg_hit(input logic [3:0] c, input logic [4:0] b);
	logic [4:0] lo [5] = '{5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F};
	if (c == 4'h0)
		return 1'b0;
	if (c <= 4'h5)
		return b >= 6'h20 - (6'h01 << (c - 4'h1));
	if (c >= 4'hA && c <= 4'hE)
		return b < lo[c - 4'hA];
	return 1'b1;
endfunction
`endif

// ===== verification/sfpg_gate_sva.sv
/*
 Checker of the protect gate.
 Assumes only the ports of sfpg_gate.
*/
`timescale 1ns/1ps
module sfpg_gate_sva
	import sfpg_pkg::*;
#(
	parameter int OP_CNT = OP_CYCLES
)(
	input wire logic		clk,
	input wire logic		rst_n,
	input wire logic		cs_n_pin,
	input wire logic		sclk_pin,
	input wire logic		cmd_valid,
	input wire sfpg_cmd_t		cmd,
	input wire logic		active_ff,
	input wire logic		sample_ff,
	input wire logic		shift_ff,
	input wire logic		busy_ff,
	input wire logic		write_enable_latch_ff,
	input wire logic		deep_power_down_ff,
	input wire logic [3:0]		protect_code_ff,
	input wire logic [1:0]		security_reg_ff,
	input wire sfpg_verdict_t	verdict_ff
);
	// Own reference of the protect table, kept apart from the bench's copy on purpose.
	function automatic logic prot_ref(input logic [3:0] c, input logic [4:0] b);
		logic [5:0] lo;
		logic [5:0] hi;
		lo = 6'h00;
		hi = 6'h20;
		case (c)
			4'h0: lo = 6'h20;
			4'h1: lo = 6'h1F;
			4'h2: lo = 6'h1E;
			4'h3: lo = 6'h1C;
			4'h4: lo = 6'h18;
			4'h5: lo = 6'h10;
			4'hA: hi = 6'h10;
			4'hB: hi = 6'h18;
			4'hC: hi = 6'h1C;
			4'hD: hi = 6'h1E;
			4'hE: hi = 6'h1F;
			default: hi = 6'h20;
		endcase
		return ({1'b0, b} >= lo) && ({1'b0, b} < hi);
	endfunction

	logic		cs_d_ff;
	logic [2:0]	bits_ff;
	logic [2:0]	nxt_bits;
	int		busy_len_ff;
	int		nxt_busy_len;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Bits of the frame modulo eight; cleared as chip-select falls.
	always_comb
	begin
		nxt_bits = (cs_d_ff && !cs_n_pin) ? 3'h0 : bits_ff + {2'h0, sample_ff};
		nxt_busy_len = busy_ff ? busy_len_ff + 1 : 0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_d_ff <= 1'b1;
			bits_ff <= 3'h0;
			busy_len_ff <= 0;
		end
		else
		begin
			cs_d_ff <= cs_n_pin;
			bits_ff <= nxt_bits;
			busy_len_ff <= nxt_busy_len;
		end
	end

	sequence write_enable_cmd_end_s;
		$rose(cs_n_pin) && cmd_valid && cmd.cls == SFPG_CLS_WRITE_ENABLE_CMD;
	endsequence
	sequence verdict_s;
		verdict_ff.exec || verdict_ff.rejected;
	endsequence

	verdict_time_a: assert property (write_enable_cmd_end_s |-> ##[3:5] verdict_s)
		else $error("no verdict");
	bit_sample_a: assert property ($rose(sclk_pin) && active_ff |-> ##[1:4] sample_ff)
		else $error("edge not sampled");
	shift_pulse_a: assert property ($fell(sclk_pin) && active_ff |-> ##[1:4] shift_ff)
		else $error("falling edge not seen");
	byte_bound_a: assert property (verdict_ff.exec |-> bits_ff == 3'h0)
		else $error("off boundary");
	latch_need_a: assert property (verdict_ff.exec && cmd.cls inside {SFPG_CLS_WRITE_STATUS_CMD,
		SFPG_CLS_PROG, SFPG_CLS_ERASE} |-> $past(write_enable_latch_ff, 2))
		else $error("no latch");
	block_prot_a: assert property (verdict_ff.exec && cmd.cls == SFPG_CLS_PROG
		&& !verdict_ff.otp_target |-> !prot_ref(protect_code_ff, cmd.addr[20:16]))
		else $error("protected block written");
	lock_hold_a: assert property (!$fell(security_reg_ff[0]) && !$fell(security_reg_ff[1]))
		else $error("lock cleared");
	busy_len_a: assert property ($fell(busy_ff) |-> busy_len_ff == OP_CNT)
		else $error("busy length");
	power_down_a: assert property (verdict_ff.exec && $past(deep_power_down_ff, 2)
		|-> cmd.cls inside {SFPG_CLS_RDP, SFPG_CLS_RST})
		else $error("ran in power-down");
endmodule

bind sfpg_gate sfpg_gate_sva #(.OP_CNT(OP_CNT)) u_sva (.clk, .rst_n, .cs_n_pin, .sclk_pin,
	.cmd_valid, .cmd, .active_ff, .sample_ff, .shift_ff, .busy_ff, .write_enable_latch_ff,
	.deep_power_down_ff, .protect_code_ff, .security_reg_ff, .verdict_ff);

// ===== verification/sfpg_host.sv
/*
 Host controller model: chip-select and serial clock frames.
 Assumes a caller that supplies the command class.
*/
`timescale 1ns/1ps
module sfpg_host (
	output logic	cs_n,
	output logic	sclk
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end

	// Both modes give one rising edge per bit, so counts match.
	task automatic frame(input logic mode3, input int n);
		sclk = mode3;
		#100 cs_n = 1'b0;
		repeat (n)
		begin
			#100 sclk = ~sclk;
			#100 sclk = ~sclk;
		end
		#100 cs_n = 1'b1;
	endtask
endmodule

// ===== verification/sfpg_gate_tb.sv
/*
 Bench of the protect gate; verdicts are checked from a queue.
 Assumes sfpg_host and the bound checker.
*/
`timescale 1ns/1ps
module sfpg_gate_tb;
	import sfpg_pkg::*;
`include "sfpg_ref.svh"
	logic		clk, rst_n, cs_n_pin, sclk_pin, cmd_valid;
	logic		wp_n_pin = 1'b1;
	logic		quad_mode = 1'b0;
	logic		active_ff, so_oe_n_ff, sample_ff, busy_ff, secured_mode_ff;
	logic		write_enable_latch_ff, deep_power_down_ff, status_write_protect_ff;
	logic [3:0]	protect_code_ff;
	logic [1:0]	security_reg_ff;
	logic [7:0]	e;
	logic [23:0]	a;
	logic [7:0]	exp_q [$];
	sfpg_cmd_t	cmd;
	sfpg_verdict_t	verdict_ff;
	int		error_cnt, samples_checked, seed, i, k;
	sfpg_cls_t	wr_cls [10] = '{SFPG_CLS_WRITE_ENABLE_CMD, SFPG_CLS_WRITE_DISABLE_CMD, SFPG_CLS_WRITE_STATUS_CMD, SFPG_CLS_PROG,
		SFPG_CLS_ERASE, SFPG_CLS_DPD, SFPG_CLS_ENTER_SECURED_REGION_CMD, SFPG_CLS_EXIT_SECURED_REGION_CMD, SFPG_CLS_WRSEC, SFPG_CLS_RST};

	sfpg_gate #(.OP_CNT(100)) dut (.clk, .rst_n, .cs_n_pin, .sclk_pin, .wp_n_pin, .quad_mode,
		.cmd_valid, .cmd, .active_ff, .so_oe_n_ff, .sample_ff, .shift_ff(), .busy_ff,
		.write_enable_latch_ff, .secured_mode_ff, .deep_power_down_ff, .protect_code_ff,
		.status_write_protect_ff, .security_reg_ff, .verdict_ff);
	sfpg_host host (.cs_n(cs_n_pin), .sclk(sclk_pin));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check_state(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_verdict(input logic [3:0] got, input logic [3:0] exp, input logic [3:0] m);
		check_state(got & m, exp);
	endtask

	// An empty queue expects an impossible verdict, so a stray pulse is caught.
	// Looked at on the falling edge, half a cycle after the pulse was launched.
	always @(negedge clk)
		if ((verdict_ff.exec | verdict_ff.rejected) === 1'b1)
		begin
			e = exp_q.size() ? exp_q.pop_front() : 8'hFF;
			check_verdict(verdict_ff, e[7:4], e[3:0]);
		end

	task automatic xfer(sfpg_cls_t c, logic [23:0] ad, logic [3:0] p, int n, logic [7:0] ev);
		for (k = 0; k < 300 && busy_ff !== 1'b0; k++)
			@(posedge clk);
		@(posedge clk);
		#2;
		cmd = '{c, ad, p, 1'b1, 1'b0};
		cmd_valid = 1'b1;
		if (ev[3:0] != 4'h0)
			exp_q.push_back(ev);
		host.frame(1'($random(seed)), n);
		repeat (8) @(posedge clk);
	endtask

	task automatic write_enable_cmd;
		xfer(SFPG_CLS_WRITE_ENABLE_CMD, 24'h0, 4'h0, 8, 8'h8F);
	endtask

	task automatic midframe(sfpg_cls_t c, logic [3:0] exp, logic [3:0] m);
		fork
			xfer(c, 24'h0, 4'h0, 13, 8'h00);
			begin
				repeat (40) @(posedge clk);
				check_verdict({2'h0, active_ff, so_oe_n_ff}, exp, m);
			end
		join
	endtask

	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		conclude;
	end

	initial
	begin
		seed = 72555;
		error_cnt = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		repeat (4) @(posedge clk);
		#2 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		check_state({security_reg_ff, so_oe_n_ff, write_enable_latch_ff}, 4'h2);
		foreach (wr_cls[j])
			xfer(wr_cls[j], 24'h0, 4'h0, 9 + $unsigned($random(seed)) % 7, 8'h4C);
		xfer(SFPG_CLS_WRITE_ENABLE_CMD, 24'h0, 4'h0, 16, 8'h8F);
		check_state(write_enable_latch_ff, 4'h1);
		xfer(SFPG_CLS_WRITE_DISABLE_CMD, 24'h0, 4'h0, 8, 8'h8F);
		check_state(write_enable_latch_ff, 4'h0);
		$display("framing test done");
		for (i = 0; i < 16; i++)
		begin
			a = 24'($random(seed));
			write_enable_cmd;
			xfer(SFPG_CLS_WRITE_STATUS_CMD, a, i[3:0], 8, 8'h8C);
			check_state(protect_code_ff, i[3:0]);
			write_enable_cmd;
			xfer(SFPG_CLS_PROG, a, 4'h0, 8, sfpg_hit(i[3:0], a[20:16]) ? 8'h6E : 8'h8E);
		end
		check_state(status_write_protect_ff, 4'h1);
		#2 wp_n_pin = 1'b0;
		write_enable_cmd;
		xfer(SFPG_CLS_WRITE_STATUS_CMD, a, 4'h3, 8, 8'h4C);
		check_state(protect_code_ff, 4'hF);
		#2 quad_mode = 1'b1;
		write_enable_cmd;
		xfer(SFPG_CLS_WRITE_STATUS_CMD, a, 4'h3, 8, 8'h8C);
		check_state(protect_code_ff, 4'h3);
		#2 wp_n_pin = 1'b1;
		quad_mode = 1'b0;
		$display("protect test done");
		xfer(SFPG_CLS_ENTER_SECURED_REGION_CMD, 24'h0, 4'h0, 8, 8'h8F);
		write_enable_cmd;
		xfer(SFPG_CLS_PROG, 24'h1F_0010, 4'h0, 8, 8'h99);
		write_enable_cmd;
		xfer(SFPG_CLS_WRSEC, 24'h0, 4'h0, 8, 8'h8C);
		check_state(security_reg_ff, 4'h2);
		write_enable_cmd;
		xfer(SFPG_CLS_PROG, 24'h00_0020, 4'h0, 8, 8'h4C);
		xfer(SFPG_CLS_EXIT_SECURED_REGION_CMD, 24'h0, 4'h0, 8, 8'h8F);
		check_state(secured_mode_ff, 4'h0);
		$display("secured test done");
		write_enable_cmd;
		xfer(SFPG_CLS_DPD, 24'h0, 4'h0, 8, 8'h8C);
		xfer(SFPG_CLS_WRITE_ENABLE_CMD, 24'h0, 4'h0, 8, 8'h4C);
		xfer(SFPG_CLS_RDP, 24'h0, 4'h0, 8, 8'h8C);
		check_state(deep_power_down_ff, 4'h0);
		midframe(SFPG_CLS_READ, 4'h2, 4'h3);
		midframe(SFPG_CLS_BAD, 4'h1, 4'h3);
		$display("power and frame test done");
		conclude;
	end
endmodule
